// file: testbench/eth_phy_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Far side: frames, carrier and gap ticks.
// ----------------------------------------
module eth_phy_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [7:0] desc_in,
  input wire logic fcs_in,
  input wire logic odd_in,
  input wire logic carrier_req_in,
  output var eth_rx_status_pkg::rx_event_t rx_event_out = '0,
  output logic rx_active_out,
  output logic carrier_out,
  output logic tick_out
);
  import eth_rx_status_pkg::*;
  logic [1:0] len_q = 2'h0;
  logic tick_q = 1'b0;
  // A frame runs three cycles; attributes are scrambled outside the end strobe.
  always @(posedge clk_in) begin
    tick_q <= !tick_q;
    len_q <= go_in ? 2'h3 : len_q - {1'b0, len_q != 2'h0};
    rx_event_out <= (len_q == 2'h1) ? {1'b1, desc_in, fcs_in, odd_in} : {1'b0, ~rx_event_out[9:0]};
  end
  assign rx_active_out = len_q != 2'h0;
  assign carrier_out = carrier_req_in;
  assign tick_out = tick_q;
endmodule
`default_nettype wire

// file: testbench/eth_rx_status_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "eth_rx_status_defs.svh"
// ----------------------------------------
// Self-checking bench.
// ----------------------------------------
module eth_rx_status_bench;
  import eth_rx_status_pkg::*;
  logic ref_clk_in = 0, rst_in = 1;
  logic [11:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, rd_data;
  logic [3:0] s_axi_wstrb_in = 0;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rd_resp;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  rx_event_t rx_event_in;
  tx_side_t tx_side_in = 0;
  logic rx_active_in, carrier_sense_in, gap_tick_in, rx_halt_out, packet_pending_flag_out;
  logic packet_pending_irq_out, module_busy_flag_out, transmit_busy_flag_out, receive_busy_flag_out;
  logic tx_defer_out, tx_go_out, frm_go = 0, frm_fcs = 0, frm_odd = 0, carrier_req = 0;
  logic [7:0] frm_desc = 0;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  eth_rx_status DUT (.ref_clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .rx_event_in, .rx_active_in,
    .tx_side_in, .carrier_sense_in, .gap_tick_in, .rx_halt_out, .packet_pending_flag_out,
    .packet_pending_irq_out, .module_busy_flag_out, .transmit_busy_flag_out, .receive_busy_flag_out,
    .tx_defer_out, .tx_go_out);
  eth_phy_model PHY (.clk_in(ref_clk_in), .go_in(frm_go), .desc_in(frm_desc), .fcs_in(frm_fcs),
    .odd_in(frm_odd), .carrier_req_in(carrier_req), .rx_event_out(rx_event_in),
    .rx_active_out(rx_active_in), .carrier_out(carrier_sense_in), .tick_out(gap_tick_in));
  initial begin
    forever #5 ref_clk_in = !ref_clk_in;
  end
  // The hang limit is far above the few hundred cycles the run needs.
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out;
    end
  end
  task automatic close_out;
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Address and data go out together; each is released once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= 4'hF;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    s_axi_bready_in <= 1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 0;
    @(posedge ref_clk_in);
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    s_axi_rready_in <= 1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 0;
    end while (s_axi_rvalid_out !== 1'b1);
    rd_data = s_axi_rdata_out;
    rd_resp = s_axi_rresp_out;
    s_axi_rready_in <= 0;
  endtask
  task automatic frame(input logic [7:0] n, input logic f, input logic o);
    frm_desc <= n;
    frm_fcs <= f;
    frm_odd <= o;
    frm_go <= 1;
    @(posedge ref_clk_in);
    frm_go <= 0;
    repeat (6) @(posedge ref_clk_in);
  endtask
  task automatic hit(ref logic s);
    for (int i = 0; i < 100 && s !== 1'b1; i++) @(posedge ref_clk_in);
    chk(s, 1);
  endtask
  task automatic s_count;
    rd(`OFF_GAP_CFG);
    chk(rd_data, 32'h0000_0C12);
    rd(12'h100);
    chk(rd_data, `ZERO32);
    chk(rd_resp, `RESP_SLVERR);
    wr(`OFF_CONTROL, 32'h0000_8002);
    frame(8'hFE, 0, 0);
    rd(`OFF_STATUS);
    chk(rd_data[23:16], 8'hFE);
    frame(8'h03, 0, 0);
    rd(`OFF_STATUS);
    chk({rd_data[23:16], rd_data[8], rx_halt_out}, {`CNT_MAX, 2'b11});
    frame(8'h01, 0, 0);
    wr(`OFF_CONTROL, 32'h0000_8003);
    rd(`OFF_STATUS);
    chk({rd_data[23:16], rx_halt_out}, {8'hFE, 1'b0});
    wr(`OFF_CONTROL, 32'h0000_8000);
    frame(8'h02, 0, 0);
    frame(8'h02, 0, 0);
    rd(`OFF_STATUS);
    chk({rd_data[23:16], rx_halt_out}, {`CNT_MAX, 1'b0});
  endtask
  task automatic s_off;
    wr(`OFF_CONTROL, 0);
    rd(`OFF_STATUS);
    chk(rd_data[23:16], `CNT_MAX);
    wr(`OFF_RX_START, 32'h0000_1000);
    rd(`OFF_STATUS);
    chk(rd_data[23:8], 0);
    wr(`OFF_CONTROL, 1);
    rd(`OFF_STATUS);
    chk(rd_data[23:16], `CNT_ZERO);
    wr(`OFF_CONTROL, 32'h0000_8004);
    frame(8'h01, 0, 0);
    chk(packet_pending_irq_out, 1);
    wr(`OFF_CONTROL, 32'h0000_8000);
    chk({packet_pending_flag_out, packet_pending_irq_out}, 2'b10);
    // The decrement is timed so that its write completes on the edge that takes the frame end.
    fork
      frame(8'h01, 0, 0);
      begin
        repeat (3) @(posedge ref_clk_in);
        wr(`OFF_CONTROL, 32'h0000_8001);
      end
    join
    rd(`OFF_STATUS);
    chk(rd_data[23:16], 8'h01);
  endtask
  task automatic s_busy;
    tx_side_in <= 2'b01;
    repeat (2) @(posedge ref_clk_in);
    chk({module_busy_flag_out, transmit_busy_flag_out}, 2'b11);
    wr(`OFF_CONTROL, 0);
    chk({module_busy_flag_out, transmit_busy_flag_out, receive_busy_flag_out}, 3'b100);
    tx_side_in <= 0;
    repeat (2) @(posedge ref_clk_in);
    chk(module_busy_flag_out, 0);
  endtask
  task automatic s_align;
    wr(`OFF_CONTROL, 32'h0000_8000);
    rd(`OFF_ALIGN_ERR);
    frame(0, 1, 1);
    frame(0, 1, 1);
    frame(0, 1, 0);
    frame(0, 0, 1);
    rd(`OFF_ALIGN_ERR);
    chk(rd_data, 2);
    rd(`OFF_ALIGN_ERR);
    chk(rd_data, 0);
    wr(`OFF_ALIGN_ERR, 32'h0000_0005);
    rd(`OFF_ALIGN_ERR);
    chk(rd_data, 32'h0000_0005);
  endtask
  // Short first gap, long second gap, so late carrier lands in the second phase.
  task automatic s_gap;
    wr(`OFF_GAP_CFG, 32'h0000_0210);
    carrier_req <= 1;
    tx_side_in <= 2'b10;
    hit(tx_defer_out);
    carrier_req <= 0;
    hit(tx_go_out);
    tx_side_in <= 0;
    repeat (40) @(posedge ref_clk_in);
    tx_side_in <= 2'b10;
    repeat (8) @(posedge ref_clk_in);
    carrier_req <= 1;
    hit(tx_go_out);
    tx_side_in <= 0;
    carrier_req <= 0;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 0;
    repeat (2) @(posedge ref_clk_in);
    s_count;
    s_off;
    s_busy;
    s_align;
    s_gap;
    close_out;
  end
endmodule
`default_nettype wire

// file: testbench/eth_rx_status_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port checker for the receive status block.
// ----------------------------------------
module eth_rx_status_chk (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire eth_rx_status_pkg::rx_event_t rx_event_in,
  input wire logic rx_active_in,
  input wire eth_rx_status_pkg::tx_side_t tx_side_in,
  input wire logic carrier_sense_in,
  input wire logic rx_halt_out,
  input wire logic packet_pending_flag_out,
  input wire logic packet_pending_irq_out,
  input wire logic module_busy_flag_out,
  input wire logic transmit_busy_flag_out,
  input wire logic receive_busy_flag_out,
  input wire logic tx_defer_out,
  input wire logic tx_go_out
);
  import eth_rx_status_pkg::*;
  logic [3:0] aw_hist_q;
  // Recent write-address valids; only a write may empty the counter.
  always_ff @(posedge ref_clk_in) begin
    aw_hist_q <= rst_in ? 4'h0 : {aw_hist_q[2:0], s_axi_awvalid_in};
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_halt_needs_pend: assert property (rx_halt_out |-> packet_pending_flag_out)
    else $error("halt with empty counter");
  a_irq_needs_pend: assert property (packet_pending_irq_out |-> packet_pending_flag_out)
    else $error("irq without pending");
  a_pend_write_drop: assert property ($fell(packet_pending_flag_out) |-> |aw_hist_q)
    else $error("counter emptied without a write");
  a_txb_needs_act: assert property (transmit_busy_flag_out |-> tx_side_in.active)
    else $error("tx busy while idle");
  a_txb_needs_on: assert property (transmit_busy_flag_out |-> module_busy_flag_out)
    else $error("tx busy while off");
  a_rxb_source: assert property (receive_busy_flag_out |-> rx_active_in || rx_event_in.done)
    else $error("rx busy without traffic");
  a_busy_traffic: assert property (rx_active_in || tx_side_in.active |-> module_busy_flag_out)
    else $error("module idle during traffic");
  a_go_one_cycle: assert property (tx_go_out |=> !tx_go_out)
    else $error("go longer than one cycle");
  a_go_not_defer: assert property (tx_go_out |-> !tx_defer_out)
    else $error("go while deferring");
  a_defer_carrier: assert property ($rose(tx_defer_out) |-> carrier_sense_in || $past(carrier_sense_in))
    else $error("defer without carrier");
  a_bvalid_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped");
  c_halt: cover property (rx_halt_out);
  c_defer: cover property ($rose(tx_defer_out));
  c_go_carrier: cover property (tx_go_out && carrier_sense_in);
endmodule
bind eth_rx_status eth_rx_status_chk u_chk (.ref_clk_in, .rst_in, .s_axi_awvalid_in, .s_axi_bvalid_out,
  .s_axi_bready_in, .rx_event_in, .rx_active_in, .tx_side_in, .carrier_sense_in, .rx_halt_out,
  .packet_pending_flag_out, .packet_pending_irq_out, .module_busy_flag_out, .transmit_busy_flag_out,
  .receive_busy_flag_out, .tx_defer_out, .tx_go_out);
`default_nettype wire

// file: verilog/eth_rx_status.sv
`timescale 1ns/1ns
`default_nettype none
`include "eth_rx_status_defs.svh"

module eth_rx_status #(
  parameter int CNT_W = 8,
  parameter int ALIGN_W = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire eth_rx_status_pkg::rx_event_t rx_event_in,
  input wire logic rx_active_in,
  input wire eth_rx_status_pkg::tx_side_t tx_side_in,
  input wire logic carrier_sense_in,
  input wire logic gap_tick_in,
  output logic rx_halt_out,
  output logic packet_pending_flag_out,
  output logic packet_pending_irq_out,
  output logic module_busy_flag_out,
  output logic transmit_busy_flag_out,
  output logic receive_busy_flag_out,
  output logic tx_defer_out,
  output logic tx_go_out
);
  import eth_rx_status_pkg::*;

  state_t q, d;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Saturating add in one step: a wide sum is clamped, so no partial wrap.
  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[8] ? `CNT_MAX : s[7:0];
  endfunction

  // Byte-lane merge used for the control, alignment and gap registers; a receive start-address write does not use it.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  logic cnt_full, cnt_nonzero, rx_busy_raw, inc_ok;
  logic [31:0] ctl_word, gap_word, st_word;

  // ----------------------------------------------------------------------
  // Status decode
  // ----------------------------------------------------------------------

  // The halt only holds while flow control is enabled; otherwise DMA runs on.
  assign cnt_full = (q.count == `CNT_MAX);
  assign cnt_nonzero = (q.count != `CNT_ZERO);
  assign rx_halt_out = q.flow_en & cnt_full;
  assign inc_ok = rx_event_in.done & ~rx_halt_out;
  assign rx_busy_raw = rx_active_in | rx_event_in.done;
  assign packet_pending_flag_out = cnt_nonzero;
  assign packet_pending_irq_out = cnt_nonzero & q.pend_ie;
  // Busy sets immediately with on and lingers while traffic drains after off.
  assign module_busy_flag_out = q.on | rx_busy_raw | tx_side_in.active;
  assign transmit_busy_flag_out = q.on & tx_side_in.active;
  assign receive_busy_flag_out = q.on & rx_busy_raw;
  assign tx_defer_out = (q.gap_st == GAP_DEFER);
  assign tx_go_out = (q.gap_st == GAP_SEND);
  assign s_axi_awready_out = q.awready;
  assign s_axi_wready_out = q.wready;
  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_bresp_out = q.bresp;
  assign s_axi_arready_out = q.arready;
  assign s_axi_rvalid_out = q.rvalid;
  assign s_axi_rdata_out = q.rdata;
  assign s_axi_rresp_out = q.rresp;

  // Readback words of the plain registers.
  always_comb begin
    ctl_word = `ZERO32;
    ctl_word[`CTL_ON_BIT] = q.on;
    ctl_word[`CTL_FLOW_BIT] = q.flow_en;
    ctl_word[`CTL_PEND_IE_BIT] = q.pend_ie;
    gap_word = `ZERO32;
    gap_word[`GAP1_LSB +: 7] = q.gap1;
    gap_word[`GAP2_LSB +: 7] = q.gap2;
    st_word = `ZERO32;
    st_word[`ST_CNT_LSB +: 8] = q.count;
    st_word[`ST_PEND_BIT] = cnt_nonzero;
    st_word[`ST_MOD_BUSY_BIT] = module_busy_flag_out;
    st_word[`ST_TX_BUSY_BIT] = transmit_busy_flag_out;
    st_word[`ST_RX_BUSY_BIT] = receive_busy_flag_out;
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Bus handshakes, counters and the gap sequencer all update here.
  always_comb begin
    logic wr_go, rd_go, dec, inc, align_clr, align_inc;
    logic [31:0] m;
    d = q;
    dec = 1'b0;
    align_clr = 1'b0;
    inc = 1'b0;
    align_inc = 1'b0;
    wr_go = q.aw_held & q.w_held & ~q.bvalid;
    rd_go = s_axi_arvalid_in & q.arready;
    m = merge(ctl_word, q.wdata, q.wstrb);

    // Address and data are latched independently, in either order.
    d.awready = ~q.aw_held & ~s_axi_awvalid_in ? 1'b1 : 1'b0;
    if (s_axi_awvalid_in & q.awready) begin
      d.awaddr = s_axi_awaddr_in;
      d.aw_held = 1'b1;
      d.awready = 1'b0;
    end else if (~q.aw_held) begin
      d.awready = 1'b1;
    end
    if (s_axi_wvalid_in & q.wready) begin
      d.wdata = s_axi_wdata_in;
      d.wstrb = s_axi_wstrb_in;
      d.w_held = 1'b1;
      d.wready = 1'b0;
    end else begin
      d.wready = ~q.w_held;
    end

    // Register write effects.
    if (wr_go) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `RESP_OKAY;
      unique case (q.awaddr)
        `OFF_CONTROL: begin
          d.on = m[`CTL_ON_BIT];
          d.flow_en = m[`CTL_FLOW_BIT];
          d.pend_ie = m[`CTL_PEND_IE_BIT];
          dec = q.wstrb[0] & q.wdata[`CTL_DEC_BIT];
        end
        `OFF_RX_START: d.count = `CNT_ZERO;
        `OFF_STATUS: ;
        `OFF_ALIGN_ERR: begin
          m = merge({16'h0000, q.align_cnt}, q.wdata, q.wstrb);
          d.align_cnt = m[15:0];
        end
        `OFF_GAP_CFG: begin
          m = merge(gap_word, q.wdata, q.wstrb);
          d.gap1 = m[`GAP1_LSB +: 7];
          d.gap2 = m[`GAP2_LSB +: 7];
        end
        default: d.bresp = `RESP_SLVERR;
      endcase
    end
    if (q.bvalid & s_axi_bready_in) begin
      d.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    d.arready = ~q.rvalid & ~rd_go;
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp = `RESP_OKAY;
      unique case (s_axi_araddr_in)
        `OFF_CONTROL: d.rdata = ctl_word;
        `OFF_RX_START: d.rdata = `ZERO32;
        `OFF_STATUS: d.rdata = st_word;
        `OFF_ALIGN_ERR: begin
          d.rdata = {16'h0000, q.align_cnt};
          align_clr = 1'b1;
        end
        `OFF_GAP_CFG: d.rdata = gap_word;
        default: begin
          d.rdata = `ZERO32;
          d.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid & s_axi_rready_in) begin
      d.rvalid = 1'b0;
    end

    // Buffer counter; turning off never clears it.
    inc = inc_ok & (rx_event_in.descriptors != `CNT_ZERO);
    if (wr_go & (q.awaddr == `OFF_RX_START)) begin
      d.count = `CNT_ZERO;
    end else if (inc & dec) begin
      d.count = q.count;
    end else if (inc) begin
      d.count = sat_add(q.count, rx_event_in.descriptors);
    end else if (dec & cnt_nonzero) begin
      d.count = q.count - 8'h01;
    end

    // Alignment errors: an event arriving with a clearing read is kept.
    align_inc = rx_event_in.done & rx_event_in.fcs_error & rx_event_in.odd_bits;
    if (align_clr) begin
      d.align_cnt = align_inc ? 16'h0001 : 16'h0000;
    end else if (align_inc) begin
      // Builds on any value written this cycle, so a debug write and an event both count.
      d.align_cnt = d.align_cnt + 16'h0001;
    end

    // Non-back-to-back gap timing and carrier deference.
    unique case (q.gap_st)
      GAP_IDLE: begin
        if (q.on & tx_side_in.request) begin
          d.gap_st = GAP_ONE;
          d.gap_tmr = 7'h00;
        end
      end
      GAP_ONE: begin
        if (carrier_sense_in) begin
          d.gap_st = GAP_DEFER;
        end else if (q.gap_tmr >= q.gap1) begin
          d.gap_st = GAP_TWO;
        end else if (gap_tick_in) begin
          d.gap_tmr = q.gap_tmr + 7'h01;
        end
      end
      GAP_TWO: begin
        // Carrier is ignored here to keep access to the medium fair.
        if (q.gap_tmr >= q.gap2) begin
          d.gap_st = GAP_SEND;
        end else if (gap_tick_in) begin
          d.gap_tmr = q.gap_tmr + 7'h01;
        end
      end
      GAP_DEFER: begin
        if (~carrier_sense_in) begin
          d.gap_st = GAP_ONE;
          d.gap_tmr = 7'h00;
        end
      end
      GAP_SEND: d.gap_st = GAP_IDLE;
      default: d.gap_st = GAP_IDLE;
    endcase
    if (~q.on & (q.gap_st != GAP_SEND)) begin
      d.gap_st = GAP_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Synchronous reset puts every field at a constant.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '0;
      q.gap1 <= `GAP1_RESET;
      q.gap2 <= `GAP2_RESET;
      q.gap_st <= GAP_IDLE;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// file: verilog/eth_rx_status_defs.svh
// How it works
// - After each receive event, with or without check error, add that packet's descriptor count to the 8-bit buffer counter.
// - Increment at maximum leaves the counter at maximum, never wrapping.
// - Decrement at zero leaves the counter at zero.
// - Coinciding decrement and increment leave the counter unchanged.
// - With flow control on, receive halts at maximum until software decrements.
// - With flow control off, receive DMA keeps running while the counter saturates.
// - Packet-pending flag is high when counter non-zero; interrupt only if enabled.
// - Writing the receive start-address register clears the buffer counter.
// - Turning the module off does not clear the buffer counter.
// - Module busy sets on switch-on, stays until transactions finish after switch-off.
// - Transmit busy reads one while a packet is transmitted.
// - Transmit busy may fall without a transmit-done interrupt.
// - Transmit and receive busy are forced to zero while the module is off.
// - Alignment-error counter counts receive frames with check error and odd bit length.
// - Reading the alignment counter always clears it, whatever the byte enables.
// - Carrier during the first gap interval makes the MAC defer.
// - Carrier after the first gap interval: finish second gap and transmit anyway.
`ifndef ETH_RX_STATUS_DEFS_SVH
`define ETH_RX_STATUS_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFF_CONTROL 12'h000
`define OFF_RX_START 12'h004
`define OFF_STATUS 12'h008
`define OFF_ALIGN_ERR 12'h00C
`define OFF_GAP_CFG 12'h010

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTL_DEC_BIT 0
`define CTL_FLOW_BIT 1
`define CTL_PEND_IE_BIT 2
`define CTL_ON_BIT 15
`define ST_CNT_LSB 16
`define ST_PEND_BIT 8
`define ST_MOD_BUSY_BIT 7
`define ST_TX_BUSY_BIT 6
`define ST_RX_BUSY_BIT 5
`define GAP1_LSB 8
`define GAP2_LSB 0

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define CNT_MAX 8'hFF
`define CNT_ZERO 8'h00
`define GAP1_RESET 7'h0C
`define GAP2_RESET 7'h12
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO32 32'h0000_0000

`endif

// file: verilog/eth_rx_status_pkg.sv
package eth_rx_status_pkg;

  // Transmit deference sequencer states.
  typedef enum logic [2:0] {
    GAP_IDLE = 3'b000,
    GAP_ONE = 3'b001,
    GAP_TWO = 3'b010,
    GAP_DEFER = 3'b011,
    GAP_SEND = 3'b100
  } gap_state_t;

  // Receive event from the MAC: one-cycle strobe with its attributes.
  typedef struct packed {
    logic done;
    logic [7:0] descriptors;
    logic fcs_error;
    logic odd_bits;
  } rx_event_t;

  // Transmit side state reported by the MAC.
  typedef struct packed {
    logic request;
    logic active;
  } tx_side_t;

  // All state of the block.
  typedef struct packed {
    logic on;
    logic flow_en;
    logic pend_ie;
    logic [7:0] count;
    logic [15:0] align_cnt;
    logic [6:0] gap1;
    logic [6:0] gap2;
    gap_state_t gap_st;
    logic [6:0] gap_tmr;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [11:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
  } state_t;

endpackage
